// [tb/wppd_pins.sv]
/* Board-side model of the 32 port pins.
   Assumes pin_oe high means the port drives the line. */
`default_nettype none
module wppd_pins (
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe,
    input wire logic [31:0] ext_val,
    output logic [31:0] pin_in
);
    timeunit 1ns;
    timeprecision 100ps;
    // A line carries the port's level where driven, else the board's.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule
`default_nettype wire

// [tb/wppd_port_checker.sv]
/* Assertions on the port data block's bus and pin ports.
   Assumes it is bound to wppd_port and runs on ref_clk. */
`default_nettype none
module wppd_port_checker #(
    parameter int LINES = 32
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] op_mode,
    input wire logic pkg_144,
    input wire logic [31:0] line_direction_bits,
    input wire logic [31:0] other_func_sel,
    input wire logic [31:0] other_func_oe,
    input wire logic [31:0] ext_bus_oe,
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe
);
    logic [31:0] plain_oe;
    logic mapped;
    // Expected drive of lines outside the bus role, and the decode.
    assign plain_oe = (other_func_sel & other_func_oe)
        | (~other_func_sel & line_direction_bits);
    assign mapped = paddr == wppd_pkg::UPPER_ADDR
        || paddr == wppd_pkg::LOWER_ADDR;
    // All checks share one clock; all but the reset check are disabled during the power-on reset.
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);
    a_ready_after_access: assert property (
        psel && penable && !pready |=> pready)
        else $error("no ready one cycle after access");
    a_ready_one_pulse: assert property (
        pready |=> !pready) else $error("ready held too long");
    a_ready_has_cause: assert property (
        pready |-> $past(psel && penable)) else $error("stray ready");
    a_err_on_decode: assert property (
        pready |-> pslverr == !mapped) else $error("wrong error flag");
    a_read_high_zero: assert property (
        prdata[31:16] == 16'h0) else $error("read data above bit 15");
    a_reset_clears_pins: assert property (disable iff (1'b0)
        !rstn |=> pin_oe == 32'h0 && pin_out == 32'h0 && !pready)
        else $error("outputs not cleared by reset");
    a_lower_plain_oe: assert property (
        $past(rstn) && $past(op_mode) == 2'h3
        |-> pin_oe[15:0] == $past(plain_oe[15:0]))
        else $error("lower drive wrong in single chip mode");
    a_lower_bus_oe: assert property (
        $past(rstn) && $past(op_mode) == 2'h1
        |-> pin_oe[15:0] == $past(ext_bus_oe[15:0]))
        else $error("lower lines not bus driven");
    a_upper_no_pins: assert property (
        $past(rstn) && !$past(pkg_144) |-> pin_oe[31:16] == 16'h0)
        else $error("upper lines driven in small package");
    c_refused: cover property (pslverr);
    c_read_data: cover property (pready && prdata != 32'h0);
    c_small_pkg: cover property (!pkg_144 && pready);
endmodule
bind wppd_port wppd_port_checker #(.LINES(LINES)) u_chk (.ref_clk, .rstn,
    .psel, .penable, .paddr, .prdata, .pready, .pslverr, .op_mode,
    .pkg_144, .line_direction_bits, .other_func_sel, .other_func_oe,
    .ext_bus_oe, .pin_out, .pin_oe);
`default_nettype wire

// [tb/wppd_port_tb.sv]
/* Self-checking bench for the port data block.
   Assumes the pin model wppd_pins and the bound checker. */
`default_nettype none
module wppd_port_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk, pready, pslverr, e;
    logic rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic pkg_144 = 1'b1;
    logic [11:0] paddr = 12'h0;
    logic [3:0] pstrb = 4'h0;
    logic [1:0] op_mode = 2'h3;
    logic [31:0] pwdata = 32'h0, dir = 32'h0, ofs = 32'h0, bsel = 32'h0;
    logic [31:0] boe = 32'h0, ext = 32'h0, prdata, pout, poe, pin, q;
    logic [31:0] ofo = 32'h0, ofe = 32'h0, bout = 32'h0, lvl;
    int n_mismatch = 0;
    int n_compared = 0;
    localparam logic [11:0] UP = wppd_pkg::UPPER_ADDR;
    localparam logic [11:0] LO = wppd_pkg::LOWER_ADDR;
    // Port under test; function and bus sources come from the bench.
    wppd_port DUT (.ref_clk, .rstn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .op_mode, .pkg_144,
        .line_direction_bits(dir), .other_func_sel(ofs),
        .other_func_out(ofo), .other_func_oe(ofe),
        .ext_bus_sel(bsel), .ext_bus_out(bout), .ext_bus_oe(boe),
        .pin_in(pin), .pin_out(pout), .pin_oe(poe), .pin_level(lvl));
    wppd_pins board (.pin_out(pout), .pin_oe(poe), .ext_val(ext),
        .pin_in(pin));
    // Free-running 200 MHz clock.
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // Compares one value and counts the outcome.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: %h not %h", $time, got, exp);
        end
    endtask
    // One APB transfer, held until pready is sampled high.
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [3:0] s);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        do
            @(posedge ref_clk);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Write that must be accepted.
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s);
        apb(1'b1, a, d, s);
        chk({31'h0, e}, 32'h0);
    endtask
    // Read with expected data and error flag.
    task automatic rd(input logic [11:0] a, input logic [31:0] x,
        input logic xe);
        apb(1'b0, a, 32'h0, 4'h0);
        chk(q, x);
        chk({31'h0, e}, {31'h0, xe});
    endtask
    // Sets mode, package and line controls, then lets pins settle.
    task automatic cfg(input logic [1:0] m, input logic k,
        input logic [31:0] d, input logic [31:0] f,
        input logic [31:0] bs, input logic [31:0] bo);
        @(posedge ref_clk);
        op_mode <= m;
        pkg_144 <= k;
        dir <= d;
        ofs <= f;
        bsel <= bs;
        boe <= bo;
        repeat (6) @(posedge ref_clk);
    endtask
    // Reset values and an unmapped address.
    task automatic t_reset();
        cfg(2'h3, 1'b1, 32'hffffffff, 32'h0, 32'h0, 32'h0);
        rd(UP, 32'h0, 1'b0);
        rd(LO, 32'h0, 1'b0);
        rd(12'h004, 32'h0, 1'b1);
    endtask
    // Plain outputs in the large package, with a byte-lane write.
    task automatic t_out();
        wr(UP, 32'hffffa5c3, 4'hf);
        wr(LO, 32'h00003c5a, 4'hf);
        wr(LO, 32'h000012ff, 4'h1);
        rd(UP, 32'h0000a5c3, 1'b0);
        rd(LO, 32'h00003cff, 1'b0);
        chk(pout, 32'ha5c33cff);
        chk(poe, 32'hffffffff);
    endtask
    // Input lines read the pins and leave them alone on writes.
    task automatic t_in();
        ext <= 32'h12345678;
        cfg(2'h3, 1'b1, 32'h0, 32'h0, 32'h0, 32'h0);
        chk(lvl, 32'h12345678);
        wr(LO, 32'h0000ffff, 4'hf);
        chk(poe, 32'h0);
        rd(LO, 32'h00005678, 1'b0);
        rd(UP, 32'h00001234, 1'b0);
        cfg(2'h3, 1'b1, 32'hffffffff, 32'h0, 32'h0, 32'h0);
        rd(LO, 32'h0000ffff, 1'b0);
    endtask
    // Output lines serving another function only store.
    task automatic t_other();
        ofo <= 32'h5a5a5a5a;
        ofe <= 32'h0000ffff;
        cfg(2'h3, 1'b1, 32'hffffffff, 32'hffffffff, 32'h0, 32'h0);
        wr(LO, 32'h00000f0f, 4'hf);
        repeat (2) @(posedge ref_clk);
        chk(poe, 32'h0000ffff);
        chk(pout, 32'h5a5a5a5a);
        rd(LO, 32'h00000f0f, 1'b0);
    endtask
    // Small package keeps the upper half as storage only.
    task automatic t_small();
        cfg(2'h3, 1'b0, 32'hffffffff, 32'h0, 32'h0, 32'h0);
        wr(UP, 32'h000055aa, 4'hf);
        rd(UP, 32'h000055aa, 1'b0);
        chk(poe, 32'h0000ffff);
        cfg(2'h3, 1'b0, 32'h0, 32'h0, 32'h0, 32'h0);
        rd(UP, 32'h000055aa, 1'b0);
    endtask
    // Bus role of the lines in each extended mode.
    task automatic t_modes();
        bout <= 32'hc3c3c3c3;
        cfg(2'h1, 1'b1, 32'hffffffff, 32'h0, 32'h0, 32'h000000ff);
        chk(poe, 32'h000000ff);
        chk(pout, 32'hc3c3c3c3);
        cfg(2'h0, 1'b1, 32'hffffffff, 32'h0, 32'h0, 32'h000000ff);
        chk(poe, 32'hffff00ff);
        chk(pout, 32'h55aac3c3);
        cfg(2'h2, 1'b1, 32'hffffffff, 32'h0, 32'h0000000f, 32'h0);
        chk(poe, 32'hfffffff0);
        chk(pout, 32'h55aa0f03);
    endtask
    // A second power-on reset clears stored data.
    task automatic t_rst2();
        wr(LO, 32'h00001111, 4'hf);
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        rd(LO, 32'h0, 1'b0);
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Main sequence after a 16-cycle reset.
    initial
    begin
        repeat (16) @(posedge ref_clk);
        rstn <= 1'b1;
        t_reset();
        t_out();
        t_in();
        t_other();
        t_small();
        t_modes();
        t_rst2();
        finish_test();
    end
    // The tests need about 0.8 us; this cuts a hang short well after.
    initial
    begin
        #20us;
        n_mismatch++;
        finish_test();
    end
endmodule
`default_nettype wire

// [verilog/wppd_pkg.sv]
/*
 * Constants shared by the wide parallel port data block: register
 * indices and bus addresses, field widths, reset values, operating
 * mode codes and the bus slave state encoding.
 * Assumes a 32-bit APB and a 12-bit word-aligned local address.
 */
`default_nettype none

package wppd_pkg;

    // Port geometry: two halves of sixteen lines each.
    localparam int HALF_W = 16;
    localparam int LINES = 32;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // Printed register indices; the block base is the upper half.
    localparam logic [31:0] REG_BASE_IDX = 32'hffff83a0;
    localparam logic [31:0] UPPER_IDX = 32'hffff83a0;
    localparam logic [31:0] LOWER_IDX = 32'hffff83a2;

    // Local byte addresses: four times the index above the base.
    localparam logic [ADDR_W-1:0] UPPER_ADDR =
        12'((UPPER_IDX - REG_BASE_IDX) << 2);
    localparam logic [ADDR_W-1:0] LOWER_ADDR =
        12'((LOWER_IDX - REG_BASE_IDX) << 2);

    // Both data registers come out of power-on reset cleared.
    localparam logic [HALF_W-1:0] DATA_RESET = 16'h0000;

    // Operating mode codes as strapped by the mode pins.
    localparam logic [1:0] MODE_NOROM_NARROW = 2'h0;
    localparam logic [1:0] MODE_NOROM_WIDE = 2'h1;
    localparam logic [1:0] MODE_ROM_EXT = 2'h2;
    localparam logic [1:0] MODE_SINGLE = 2'h3;

    // Bus slave states, one-hot.
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b01,
        ST_ACK = 2'b10
    } wppd_apb_e;

endpackage

`default_nettype wire

// [verilog/wppd_port.sv]
/*
 * Data logic of a 32-line parallel port: the upper-half and
 * lower-half data registers on an APB slave, the per-line choice
 * between general port, external data bus and other functions, and
 * the pin drivers and pin read-back.
 * Assumes direction, function selects, mode and package straps come
 * from logic on ref_clk, and that pins arrive asynchronously.
 */
`default_nettype none

module wppd_port #(
    parameter int LINES = 32
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] op_mode,
    input wire logic pkg_144,
    input wire logic [31:0] line_direction_bits,
    input wire logic [31:0] other_func_sel,
    input wire logic [31:0] other_func_out,
    input wire logic [31:0] other_func_oe,
    input wire logic [31:0] ext_bus_sel,
    input wire logic [31:0] ext_bus_out,
    input wire logic [31:0] ext_bus_oe,
    input wire logic [31:0] pin_in,
    output logic [31:0] pin_out,
    output logic [31:0] pin_oe,
    output logic [31:0] pin_level
);

    localparam int HW = wppd_pkg::HALF_W;

    // Register file and bus slave state.
    logic [HW-1:0] port_upper_half_data_reg;
    logic [HW-1:0] port_upper_half_data_next;
    logic [HW-1:0] port_lower_half_data_reg;
    logic [HW-1:0] port_lower_half_data_next;
    wppd_pkg::wppd_apb_e state_reg;
    wppd_pkg::wppd_apb_e state_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;

    // Pin driver state.
    logic [31:0] pin_out_reg;
    logic [31:0] pin_out_next;
    logic [31:0] pin_oe_reg;
    logic [31:0] pin_oe_next;

    // Per-line decode.
    logic [31:0] data_all;
    logic [31:0] pin_sync;
    logic [31:0] read_view;
    logic [31:0] bus_role;
    logic [31:0] pin_present;
    logic [31:0] read_stored;
    logic [31:0] own_bus;
    logic [31:0] own_other;
    logic [31:0] own_plain;
    logic hit_upper;
    logic hit_lower;
    logic hit_any;

    // Conditioned pin levels, also offered to the bus and functions.
    // A level must pass the whole chain before software sees it, so a
    // pin caught mid-transition never reads back as a false value.
    wppd_sync #(
        .WIDTH(LINES)
    ) u_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .pin_async(pin_in),
        .pin_level(pin_sync)
    );

    // Writes land per byte lane, so 8 and 16-bit accesses work.
    // Lanes 2 and 3 have no register bits behind them and are dropped.
    function automatic logic [15:0] merge_lanes(
        input logic [15:0] old_val,
        input logic [15:0] new_val,
        input logic [1:0] lanes
    );
        logic [15:0] result;
        result = old_val;
        if (lanes[0])
        begin
            result[7:0] = new_val[7:0];
        end
        if (lanes[1])
        begin
            result[15:8] = new_val[15:8];
        end
        return result;
    endfunction

    // Both halves seen as one vector of line data.
    assign data_all = {port_upper_half_data_reg, port_lower_half_data_reg};

    // Per-line role: external data bus or not, and whether pinned out.
    // Mode and package are straps, but the decode stays combinational
    // so that a strap change still reaches the pins one cycle later.
    genvar gi;
    generate
        for (gi = 0; gi < LINES; gi++)
        begin : g_line
            if (gi < HW)
            begin : g_low
                // Lower lines always have pins.
                assign pin_present[gi] = 1'b1;
                // Lower lines follow the operating mode.
                assign bus_role[gi] =
                    (op_mode == wppd_pkg::MODE_NOROM_NARROW) ||
                    (op_mode == wppd_pkg::MODE_NOROM_WIDE) ||
                    ((op_mode == wppd_pkg::MODE_ROM_EXT) &&
                     ext_bus_sel[gi]);
            end
            else
            begin : g_high
                // Upper lines exist only in the large package.
                assign pin_present[gi] = pkg_144;
                // Wide ROM-less mode dedicates them to the data bus.
                assign bus_role[gi] = pkg_144 &&
                    ((op_mode == wppd_pkg::MODE_NOROM_WIDE) ||
                     (((op_mode == wppd_pkg::MODE_NOROM_NARROW) ||
                       (op_mode == wppd_pkg::MODE_ROM_EXT)) &&
                      ext_bus_sel[gi]));
            end
        end
    endgenerate

    // Output lines, and lines with no pin in the small package, read
    // their stored bit; a pinless line would otherwise return whatever
    // floats on a pad that does not exist.
    assign read_stored = line_direction_bits | ~pin_present;

    // Read view: stored bit where chosen above, live level elsewhere.
    always_comb
    begin
        read_view = (read_stored & data_all)
                  | (~read_stored & pin_sync);
    end

    // Address decode over the two register words.
    assign hit_upper = (paddr == wppd_pkg::UPPER_ADDR);
    assign hit_lower = (paddr == wppd_pkg::LOWER_ADDR);

    // Anything else in the window is refused with an error response.
    assign hit_any = hit_upper || hit_lower;

    // Bus slave: one wait state, then the answer with pready high.
    // The read word is captured when the access phase is first seen,
    // so prdata is a flop and stands still through the pready cycle.
    // Writes wait for the pready edge, so a master that abandons the
    // access early never changes a register.
    always_comb
    begin
        state_next = state_reg;
        prdata_next = prdata_reg;
        pready_next = 1'b0;
        pslverr_next = 1'b0;
        port_upper_half_data_next = port_upper_half_data_reg;
        port_lower_half_data_next = port_lower_half_data_reg;
        case (state_reg)
            wppd_pkg::ST_IDLE:
            begin
                if (psel && penable)
                begin
                    state_next = wppd_pkg::ST_ACK;
                    pready_next = 1'b1;
                    pslverr_next = !hit_any;
                    // Writes and refused reads return zero data.
                    if (pwrite || !hit_any)
                    begin
                        prdata_next = 32'h0000_0000;
                    end
                    else if (hit_upper)
                    begin
                        prdata_next = {16'h0000,
                                       read_view[31:16]};
                    end
                    else
                    begin
                        prdata_next = {16'h0000, read_view[15:0]};
                    end
                end
            end
            wppd_pkg::ST_ACK:
            begin
                // The write takes effect on the edge that sees pready.
                state_next = wppd_pkg::ST_IDLE;
                if (psel && penable && pwrite)
                begin
                    if (hit_upper)
                    begin
                        port_upper_half_data_next = merge_lanes(
                            port_upper_half_data_reg, pwdata[15:0],
                            pstrb[1:0]);
                    end
                    if (hit_lower)
                    begin
                        port_lower_half_data_next = merge_lanes(
                            port_lower_half_data_reg, pwdata[15:0],
                            pstrb[1:0]);
                    end
                end
            end
            default:
            begin
                state_next = wppd_pkg::ST_IDLE;
            end
        endcase
    end

    // Only the power-on reset clears the data; otherwise only bus writes change it.
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            port_upper_half_data_reg <= wppd_pkg::DATA_RESET;
            port_lower_half_data_reg <= wppd_pkg::DATA_RESET;
            state_reg <= wppd_pkg::ST_IDLE;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            port_upper_half_data_reg <= port_upper_half_data_next;
            port_lower_half_data_reg <= port_lower_half_data_next;
            state_reg <= state_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // Owner of each pin: bus first, then other function, then plain
    // port. The bus must win so that an extended-mode data cycle is
    // never corrupted by a port or function setting left behind.
    assign own_bus = bus_role;
    assign own_other = ~bus_role & other_func_sel;
    assign own_plain = ~bus_role & ~other_func_sel;

    // Pin drivers: each owner supplies both the level and the enable.
    always_comb
    begin
        pin_out_next = (own_bus & ext_bus_out)
                     | (own_other & other_func_out)
                     | (own_plain & data_all);
        pin_oe_next = pin_present &
                      ((own_bus & ext_bus_oe)
                     | (own_other & other_func_oe)
                     | (own_plain & line_direction_bits));
    end

    // Pin outputs are registered; all pins float after reset.
    // Registering them keeps the pads free of decode glitches when the
    // mode or direction inputs change.
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            pin_out_reg <= 32'h0000_0000;
            pin_oe_reg <= 32'h0000_0000;
        end
        else
        begin
            pin_out_reg <= pin_out_next;
            pin_oe_reg <= pin_oe_next;
        end
    end

    // Outputs straight from flip-flops.
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign pin_out = pin_out_reg;
    assign pin_oe = pin_oe_reg;
    assign pin_level = pin_sync;

endmodule

`default_nettype wire

// [verilog/wppd_sync.sv]
/*
 * Pin input conditioner: three flip-flops per line, and a filtered
 * level that follows only once the second and third stages agree.
 * Assumes the pins are asynchronous to ref_clk.
 */
`default_nettype none

module wppd_sync #(
    parameter int WIDTH = 32
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] pin_async,
    output logic [WIDTH-1:0] pin_level
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;
    logic [WIDTH-1:0] level_reg;
    logic [WIDTH-1:0] level_next;

    // A line's level changes only where the last two stages agree.
    always_comb
    begin
        level_next = (stage2_reg & ~(stage2_reg ^ stage3_reg))
                   | (level_reg & (stage2_reg ^ stage3_reg));
    end

    // The first stage is read by the second stage alone.
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            stage1_reg <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
            level_reg <= '0;
        end
        else
        begin
            stage1_reg <= pin_async;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            level_reg <= level_next;
        end
    end

    assign pin_level = level_reg;

endmodule

`default_nettype wire
